/* File: egress_tag_pkg.sv */
// Shared constants and types for the egress tag rewrite block
package egress_tag_pkg;

  // ****************************************************************
  // Register map (word indexes, byte address is four times these)
  // ****************************************************************
  localparam logic [15:0] IDX_DISCARD_CMD   = 16'h1C09;
  localparam logic [15:0] IDX_DISCARD_WDATA = 16'h1C0A;
  localparam logic [15:0] IDX_DISCARD_RDATA = 16'h1C0B;
  localparam logic [15:0] IDX_EGRESS_CFG    = 16'h1C0C;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          PORT_STRIDE    = 8;
  localparam int          CFG_FIELD_W    = 7;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h007F7F7F;
  localparam logic [31:0] CMD_WRITE_MASK = 32'h0000001F;
  localparam logic [31:0] WDAT_MASK      = 32'h000003FF;
  localparam logic [31:0] CFG_RESET      = 32'h00000000;
  localparam logic [31:0] CMD_RESET      = 32'h00000000;
  localparam int          PROB_W         = 10;
  localparam int          TABLE_DEPTH    = 16;
  localparam int          INDEX_W        = 4;
  localparam int          CMD_RNW_BIT    = 4;
  localparam logic [9:0]  PROB_RESET     = 10'h000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    TYPE_DUMB   = 2'b00,
    TYPE_ACCESS = 2'b01,
    TYPE_HYBRID = 2'b10,
    TYPE_CPU    = 2'b11
  } egress_type_t;

  typedef enum logic [1:0] {
    KIND_UNTAGGED = 2'b00,
    KIND_PRIORITY = 2'b01,
    KIND_REGULAR  = 2'b10,
    KIND_SPECIAL  = 2'b11
  } tag_kind_t;

  typedef enum logic [2:0] {
    ACT_PASS    = 3'b000,
    ACT_STRIP   = 3'b001,
    ACT_INSERT  = 3'b010,
    ACT_REWRITE = 3'b011,
    ACT_CPU_TAG = 3'b100
  } tag_action_t;

  // Per-port control slice, msb first as laid out in the register
  typedef struct packed {
    logic         sel;
    logic         insert;
    logic         chg_vid;
    logic         chg_pri;
    logic         chg_tag;
    egress_type_t etype;
  } port_cfg_t;

  typedef struct packed {
    logic        valid;
    tag_kind_t   kind;
    logic [11:0] vid;
    logic [2:0]  pri;
    logic [11:0] ingress_vid;
    logic [2:0]  ingress_pri;
    logic [11:0] egress_vid;
    logic [2:0]  egress_pri;
    logic        untag_default;
    logic        untag_incoming;
    logic [1:0]  src_port;
  } pkt_desc_t;

  typedef struct packed {
    logic        valid;
    tag_action_t action;
    logic [11:0] vid;
    logic [2:0]  pri;
    logic [1:0]  src_port;
  } tag_result_t;

endpackage

/* File: egress_tag_editor.sv */
// Per-port egress tag decision with one registered result stage
`timescale 1ns/100ps
module egress_tag_editor
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire egress_tag_pkg::port_cfg_t   cfg,
  input  wire egress_tag_pkg::pkt_desc_t   desc,
  output      egress_tag_pkg::tag_result_t result
);
  import egress_tag_pkg::*;

  typedef struct packed {
    tag_result_t res;
  } editor_state_t;

  editor_state_t state;
  editor_state_t next_state;
  logic [11:0]   sel_vid;
  logic [2:0]    sel_pri;

  // ****************************************************************
  // Tag decision
  // ****************************************************************
  // Next result from port type, packet kind and control bits
  always_comb
  begin
    sel_vid = cfg.sel ? desc.egress_vid : desc.ingress_vid;
    sel_pri = cfg.sel ? desc.egress_pri : desc.ingress_pri;
    next_state              = state;
    next_state.res.valid    = desc.valid;
    next_state.res.action   = ACT_PASS;
    next_state.res.vid      = desc.vid;
    next_state.res.pri      = desc.pri;
    next_state.res.src_port = desc.src_port;
    // Control bits only matter in hybrid mode
    case (cfg.etype)
      TYPE_DUMB:
        if (desc.kind == KIND_SPECIAL)
          next_state.res.action = ACT_STRIP;
      TYPE_ACCESS:
        if (desc.kind != KIND_UNTAGGED)
          next_state.res.action = ACT_STRIP;
      TYPE_HYBRID:
        case (desc.kind)
          KIND_UNTAGGED:
            if (cfg.insert && !desc.untag_default)
            begin
              next_state.res.action = ACT_INSERT;
              next_state.res.vid    = sel_vid;
              next_state.res.pri    = sel_pri;
            end
          KIND_PRIORITY:
            // Change tag bit plays no part here
            if (desc.untag_incoming)
              next_state.res.action = ACT_STRIP;
            else
            begin
              next_state.res.action = ACT_REWRITE;
              next_state.res.vid    = sel_vid;
              if (cfg.chg_pri)
                next_state.res.pri  = sel_pri;
            end
          KIND_REGULAR:
            if (cfg.chg_tag && (cfg.chg_vid || cfg.chg_pri))
            begin
              if (desc.untag_incoming)
                next_state.res.action = ACT_STRIP;
              else
              begin
                next_state.res.action = ACT_REWRITE;
                if (cfg.chg_vid)
                  next_state.res.vid  = sel_vid;
                if (cfg.chg_pri)
                  next_state.res.pri  = sel_pri;
              end
            end
          default:
            next_state.res.action = ACT_STRIP;
        endcase
      TYPE_CPU:
        next_state.res.action = ACT_CPU_TAG;
      default:
        next_state.res.action = ACT_PASS;
    endcase
  end

  // Result register, frozen while the clock enable is low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state <= '0;
    else if (ce)
      state <= next_state;
  end

  assign result = state.res;

endmodule // egress_tag_editor

/* File: egress_tag_rewrite.sv */
// Egress tag rewrite with discard table read-back over AXI4-Lite
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
module egress_tag_rewrite
#(
  parameter int ADDR_W    = 16,
  parameter int NUM_PORTS = 3
)
(
  input  wire logic                    CLOCK,
  input  wire logic                    RST_N,
  input  wire logic                    CE,
  input  wire logic                    AWVALID,
  output      logic                    AWREADY,
  input  wire logic [ADDR_W-1:0]       AWADDR,
  input  wire logic                    WVALID,
  output      logic                    WREADY,
  input  wire logic [31:0]             WDATA,
  input  wire logic [3:0]              WSTRB,
  output      logic                    BVALID,
  input  wire logic                    BREADY,
  output      logic [1:0]              BRESP,
  input  wire logic                    ARVALID,
  output      logic                    ARREADY,
  input  wire logic [ADDR_W-1:0]       ARADDR,
  output      logic                    RVALID,
  input  wire logic                    RREADY,
  output      logic [31:0]             RDATA,
  output      logic [1:0]              RRESP,
  input  wire egress_tag_pkg::pkt_desc_t   [NUM_PORTS-1:0] DESC_IN,
  output      egress_tag_pkg::tag_result_t [NUM_PORTS-1:0] RESULT_OUT
);
  import egress_tag_pkg::*;

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  // The highest register index times four needs fifteen address bits
  if (ADDR_W < 15 || ADDR_W > 32)
  begin : bad_addr_w
    $error("ADDR_W must lie between 15 and 32");
  end
  // The control register has slices for three ports only
  if (NUM_PORTS < 1 || NUM_PORTS > 3)
  begin : bad_num_ports
    $error("NUM_PORTS must lie between 1 and 3");
  end
  // The command index must reach every table entry, no more
  if ((1 << INDEX_W) != TABLE_DEPTH)
  begin : bad_index_w
    $error("INDEX_W does not match TABLE_DEPTH");
  end
  // A port slice must fit its stride and the port struct
  if (CFG_FIELD_W > PORT_STRIDE || $bits(port_cfg_t) != CFG_FIELD_W)
  begin : bad_cfg_field
    $error("port slice does not fit its stride");
  end
  // A probability must fit in one read-data word
  if (PROB_W < 1 || PROB_W > 32)
  begin : bad_prob_w
    $error("PROB_W must lie between 1 and 32");
  end
  // The read flag must sit above the table index
  if (CMD_RNW_BIT < INDEX_W || CMD_RNW_BIT > 31)
  begin : bad_rnw_bit
    $error("CMD_RNW_BIT must lie above the index field");
  end
  // The write-data mask must open exactly the probability bits
  if (WDAT_MASK != 32'((64'd1 << PROB_W) - 64'd1))
  begin : bad_wdat_mask
    $error("WDAT_MASK does not match PROB_W");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef logic [PROB_W-1:0] prob_t;

  typedef struct packed {
    logic                         aw_got;
    logic [ADDR_W-1:0]            awaddr;
    logic                         w_got;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic [31:0]                  cmd;
    logic [31:0]                  wdat;
    prob_t                        rd_prob;
    logic [31:0]                  cfg;
    logic [TABLE_DEPTH-1:0][PROB_W-1:0] prob_table;
  } slave_state_t;

  slave_state_t state;
  slave_state_t next_state;
  logic [31:0]  new_cmd;
  logic [INDEX_W-1:0] cmd_index;
  logic [1:0]   rd_resp;
  logic [31:0]  rd_word;
  logic [15:0]  rd_index;
  logic [15:0]  wr_index;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Word index of a byte address; low two bits are ignored
  function automatic logic [15:0] word_index(
    input logic [ADDR_W-1:0] addr
  );
    logic [31:0] shifted;
    shifted    = 32'(addr) >> 2;
    word_index = shifted[15:0];
  endfunction

  // Only the four registers of this block answer OKAY
  function automatic logic is_mapped(
    input logic [15:0] idx
  );
    is_mapped = idx inside {IDX_DISCARD_CMD, IDX_DISCARD_WDATA,
                            IDX_DISCARD_RDATA, IDX_EGRESS_CFG};
  endfunction

  // Merge a write under byte strobes, keeping only writable bits
  function automatic logic [31:0] apply_strobe(
    input logic [31:0] old_val,
    input logic [31:0] data,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] merged;
    merged = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        merged[b*8 +: 8] = data[b*8 +: 8];
    end
    apply_strobe = merged & mask;
  endfunction

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // Readies drop with the clock enable so nothing is taken while frozen
  assign AWREADY = CE && !state.aw_got && !state.bvalid;
  assign WREADY  = CE && !state.w_got && !state.bvalid;
  assign ARREADY = CE && !state.rvalid;
  assign BVALID  = state.bvalid;
  assign BRESP   = state.bresp;
  assign RVALID  = state.rvalid;
  assign RDATA   = state.rdata;
  assign RRESP   = state.rresp;

  // ****************************************************************
  // Read decode
  // ****************************************************************
  // Reserved bits come back as zero in every word
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_resp = is_mapped(rd_index) ? RESP_OKAY : RESP_SLVERR;
    case (rd_index)
      IDX_DISCARD_CMD:
        rd_word = state.cmd;
      IDX_DISCARD_WDATA:
        rd_word = state.wdat;
      IDX_DISCARD_RDATA:
        rd_word[PROB_W-1:0] = state.rd_prob;
      IDX_EGRESS_CFG:
        rd_word = state.cfg & CFG_WRITE_MASK;
      default:
        rd_word = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Command word as it stands after the pending write
  assign new_cmd   = apply_strobe(state.cmd, state.wdata, state.wstrb,
                                  CMD_WRITE_MASK);
  assign cmd_index = new_cmd[INDEX_W-1:0];

  // Word indexes of the pending read and the held write address
  assign rd_index  = word_index(ARADDR);
  assign wr_index  = word_index(state.awaddr);

  // Channel bookkeeping and register effects
  always_comb
  begin
    next_state = state;
    // Address and data may arrive in either order
    if (AWVALID && AWREADY)
    begin
      next_state.aw_got = 1'b1;
      next_state.awaddr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      next_state.w_got = 1'b1;
      next_state.wdata = WDATA;
      next_state.wstrb = WSTRB;
    end
    if (state.bvalid && BREADY)
      next_state.bvalid = 1'b0;
    // Commit once both halves are held and no response is pending
    if (state.aw_got && state.w_got && !state.bvalid)
    begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = is_mapped(wr_index) ? RESP_OKAY : RESP_SLVERR;
      case (wr_index)
        IDX_DISCARD_CMD:
        begin
          next_state.cmd = new_cmd;
          // Every command write runs the command it carries
          if (new_cmd[CMD_RNW_BIT])
            next_state.rd_prob = state.prob_table[cmd_index];
          else
            next_state.prob_table[cmd_index] =
              state.wdat[PROB_W-1:0];
        end
        IDX_DISCARD_WDATA:
          next_state.wdat = apply_strobe(state.wdat, state.wdata,
                                         state.wstrb, WDAT_MASK);
        IDX_DISCARD_RDATA:
          // Read-only: write accepted and dropped
          next_state.bresp = RESP_OKAY;
        IDX_EGRESS_CFG:
          next_state.cfg = apply_strobe(state.cfg, state.wdata,
                                        state.wstrb,
                                        CFG_WRITE_MASK);
        default:
          next_state.bresp = RESP_SLVERR;
      endcase
    end
    // Read data is captured at the address handshake
    if (state.rvalid && RREADY)
      next_state.rvalid = 1'b0;
    if (ARVALID && ARREADY)
    begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = rd_word;
      next_state.rresp  = rd_resp;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // The table is cleared here as well, though software must fill it
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state            <= '0;
      state.cmd        <= CMD_RESET;
      state.cfg        <= CFG_RESET;
      state.rd_prob    <= PROB_RESET;
    end
    else if (CE)
      state <= next_state;
  end

  // ****************************************************************
  // Per-port tag editors
  // ****************************************************************
  // Each port takes its own seven-bit slice of the control word
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    port_cfg_t port_cfg;
    assign port_cfg =
      port_cfg_t'(state.cfg[p*PORT_STRIDE +: CFG_FIELD_W]);
    egress_tag_editor u_editor
    (
      .clock  (CLOCK),
      .rst_n  (RST_N),
      .ce     (CE),
      .cfg    (port_cfg),
      .desc   (DESC_IN[p]),
      .result (RESULT_OUT[p])
    );
  end

endmodule // egress_tag_rewrite

/* File: egress_tag_rewrite_monitor.sv */
// Concurrent checks on the ports of the egress tag rewrite block
`timescale 1ns/100ps
module egress_tag_rewrite_monitor
#(
  parameter int ADDR_W    = 16,
  parameter int NUM_PORTS = 3
)
(
  input wire logic                          CLOCK,
  input wire logic                          RST_N,
  input wire logic                          CE,
  input wire logic                          AWVALID,
  input wire logic                          AWREADY,
  input wire logic [ADDR_W-1:0]             AWADDR,
  input wire logic                          WVALID,
  input wire logic                          WREADY,
  input wire logic [31:0]                   WDATA,
  input wire logic [3:0]                    WSTRB,
  input wire logic                          BVALID,
  input wire logic                          BREADY,
  input wire logic [1:0]                    BRESP,
  input wire logic                          ARVALID,
  input wire logic                          ARREADY,
  input wire logic [ADDR_W-1:0]             ARADDR,
  input wire logic                          RVALID,
  input wire logic                          RREADY,
  input wire logic [31:0]                   RDATA,
  input wire logic [1:0]                    RRESP,
  input wire egress_tag_pkg::pkt_desc_t   [NUM_PORTS-1:0] DESC_IN,
  input wire egress_tag_pkg::tag_result_t [NUM_PORTS-1:0] RESULT_OUT
);
  import egress_tag_pkg::*;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // ****************************************************************
  // Register bus answers
  // ****************************************************************
  read_answer_a:
    assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  write_answer_a:
    assert property (AWVALID && AWREADY && WVALID && WREADY ##1 CE
      |=> BVALID)
    else $error("write answer late");
  read_held_a:
    assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
  rdata_reserved_a:
    assert property (ARVALID && ARREADY
      && (ARADDR >> 2) == ADDR_W'(IDX_DISCARD_RDATA)
      |=> RDATA[31:10] == 22'h000000 && RRESP == RESP_OKAY)
    else $error("probability read shows upper bits");
  cfg_reserved_a:
    assert property (ARVALID && ARREADY
      && (ARADDR >> 2) == ADDR_W'(IDX_EGRESS_CFG)
      |=> (RDATA & ~CFG_WRITE_MASK) == 32'h00000000)
    else $error("reserved config bits not zero");

  // ****************************************************************
  // Tag decisions, one set per egress port
  // ****************************************************************
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    valid_follows_a:
      assert property (CE |=> RESULT_OUT[p].valid == $past(DESC_IN[p].valid))
      else $error("result valid lost");
    untagged_no_edit_a:
      assert property (CE && DESC_IN[p].kind == KIND_UNTAGGED
        |=> !(RESULT_OUT[p].action inside {ACT_STRIP, ACT_REWRITE}))
      else $error("untagged packet edited");
    insert_needs_clear_a:
      assert property (CE && DESC_IN[p].untag_default
        |=> RESULT_OUT[p].action != ACT_INSERT)
      else $error("insert despite untag flag");
    rewrite_needs_clear_a:
      assert property (CE && DESC_IN[p].kind != KIND_UNTAGGED
        && DESC_IN[p].untag_incoming |=> RESULT_OUT[p].action != ACT_REWRITE)
      else $error("rewrite despite untag flag");
    priority_vid_a:
      assert property (CE && DESC_IN[p].kind == KIND_PRIORITY
        ##1 RESULT_OUT[p].action == ACT_REWRITE |-> RESULT_OUT[p].vid inside
        {$past(DESC_IN[p].ingress_vid), $past(DESC_IN[p].egress_vid)})
      else $error("priority tag vid not a default");
    insert_fields_a:
      assert property (CE ##1 RESULT_OUT[p].action == ACT_INSERT
        |-> RESULT_OUT[p].pri inside
        {$past(DESC_IN[p].ingress_pri), $past(DESC_IN[p].egress_pri)})
      else $error("inserted priority not a default");
  end

  // Main scenarios reached
  cover property (RESULT_OUT[2].action == ACT_INSERT);
  cover property (RESULT_OUT[2].action == ACT_STRIP);
  cover property (RVALID && RDATA[9:0] == 10'h3FF);
endmodule // egress_tag_rewrite_monitor

bind egress_tag_rewrite egress_tag_rewrite_monitor
  #(.ADDR_W(ADDR_W), .NUM_PORTS(NUM_PORTS)) u_egress_tag_rewrite_monitor
  (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
   .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
   .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
   .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
   .DESC_IN(DESC_IN), .RESULT_OUT(RESULT_OUT));

/* File: egress_tag_rewrite_bench.sv */
// Self-checking bench for the egress tag rewrite block
`timescale 1ns/100ps
module egress_tag_rewrite_bench;
  import egress_tag_pkg::*;

  logic                  clock, rst_n, ce;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [15:0]           awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  pkt_desc_t   [2:0]     desc_in;
  tag_result_t [2:0]     result_out;
  int                    failures, samples_checked;

  egress_tag_rewrite u_egress_tag_rewrite
  (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .AWVALID(awvalid),
   .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready),
   .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready),
   .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
   .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
   .DESC_IN(desc_in), .RESULT_OUT(result_out));

  // ****************************************************************
  // Clock, verdict and watchdog
  // ****************************************************************
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Generous span: the whole run needs a few hundred cycles
  initial
  begin
    #(25 * 20000);
    failures++;
    complete_run();
  end

  // ****************************************************************
  // Bus tasks: hold each channel until its own ready is seen
  // ****************************************************************
  task automatic axi_write(input logic [15:0] idx, input logic [31:0] d,
                           input logic [1:0] exp_resp);
    logic aw, w, got;
    @(posedge clock);
    awaddr  <= {idx[13:0], 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(posedge clock);
      if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
      if (bvalid)
      begin
        got = 1'b1;
        bready <= 1'b0;
        check("bresp", {30'h0, exp_resp}, {30'h0, bresp});
      end
    end
  endtask

  task automatic axi_read(input logic [15:0] idx, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
    logic ar, got;
    @(posedge clock);
    araddr  <= {idx[13:0], 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ar = 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(posedge clock);
      if (ar && arready) begin ar = 1'b0; arvalid <= 1'b0; end
      if (rvalid)
      begin
        got = 1'b1;
        rready <= 1'b0;
        check("rdata", exp, rdata);
        check("rresp", {30'h0, exp_resp}, {30'h0, rresp});
      end
    end
  endtask

  // Same slice on all three ports, so port 0 and 1 are judged too
  task automatic run_case(input logic [6:0] s, input tag_kind_t k,
    input logic ud, input logic ui, input tag_action_t act,
    input logic [11:0] v, input logic [2:0] pr);
    pkt_desc_t d;
    d = '{valid: 1'b1, kind: k, vid: 12'h789, pri: 3'h1,
          ingress_vid: 12'h123, ingress_pri: 3'h2, egress_vid: 12'h456,
          egress_pri: 3'h5, untag_default: ud, untag_incoming: ui,
          src_port: 2'h1};
    axi_write(IDX_EGRESS_CFG, {9'h000, s, 1'b0, s, 1'b0, s}, RESP_OKAY);
    @(posedge clock);
    desc_in <= {d, d, d};
    @(posedge clock);
    desc_in <= '0;
    #1;
    for (int p = 0; p < 3; p++)
    begin
      check("action", {29'h0, act}, {29'h0, result_out[p].action});
      check("valid", 32'h1, {31'h0, result_out[p].valid});
      check("src", 32'h1, {30'h0, result_out[p].src_port});
      if (act == ACT_INSERT || act == ACT_REWRITE)
      begin
        check("vid", {20'h0, v}, {20'h0, result_out[p].vid});
        check("pri", {29'h0, pr}, {29'h0, result_out[p].pri});
      end
    end
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    logic [31:0] val;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    wstrb = 4'hF;
    desc_in = '0;
    ce = 1'b1;
    rst_n = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    axi_read(IDX_EGRESS_CFG, 32'h00000000, RESP_OKAY);
    axi_read(IDX_DISCARD_RDATA, 32'h00000000, RESP_OKAY);
    axi_read(16'h1C00, 32'h00000000, RESP_SLVERR);
    axi_write(IDX_EGRESS_CFG, 32'hFFFFFFFF, RESP_OKAY);
    axi_read(IDX_EGRESS_CFG, 32'h007F7F7F, RESP_OKAY);
    $display("test registers done");
    // Distinct value per entry, the last one all ones
    for (int i = 0; i < 16; i++)
    begin
      val = (i == 15) ? 32'h000003FF : 32'(i * 65 + 1);
      axi_write(IDX_DISCARD_WDATA, val, RESP_OKAY);
      axi_write(IDX_DISCARD_CMD, 32'(i), RESP_OKAY);
    end
    for (int i = 0; i < 16; i++)
    begin
      val = (i == 15) ? 32'h000003FF : 32'(i * 65 + 1);
      axi_write(IDX_DISCARD_CMD, 32'h10 | 32'(i), RESP_OKAY);
      axi_read(IDX_DISCARD_RDATA, val, RESP_OKAY);
    end
    axi_write(IDX_DISCARD_RDATA, 32'h00000000, RESP_OKAY);
    axi_read(IDX_DISCARD_RDATA, 32'h000003FF, RESP_OKAY);
    $display("test discard table done");
    run_case(7'h62, KIND_UNTAGGED, 0, 0, ACT_INSERT, 12'h456, 3'h5);
    run_case(7'h22, KIND_UNTAGGED, 0, 0, ACT_INSERT, 12'h123, 3'h2);
    run_case(7'h62, KIND_UNTAGGED, 1, 0, ACT_PASS, 12'h000, 3'h0);
    run_case(7'h56, KIND_REGULAR, 0, 0, ACT_REWRITE, 12'h456, 3'h1);
    run_case(7'h56, KIND_REGULAR, 0, 1, ACT_STRIP, 12'h000, 3'h0);
    run_case(7'h52, KIND_REGULAR, 0, 0, ACT_PASS, 12'h000, 3'h0);
    run_case(7'h42, KIND_PRIORITY, 0, 0, ACT_REWRITE, 12'h456, 3'h1);
    run_case(7'h0A, KIND_PRIORITY, 0, 0, ACT_REWRITE, 12'h123, 3'h2);
    run_case(7'h4E, KIND_REGULAR, 0, 0, ACT_REWRITE, 12'h789, 3'h5);
    run_case(7'h4E, KIND_REGULAR, 0, 1, ACT_STRIP, 12'h000, 3'h0);
    run_case(7'h60, KIND_UNTAGGED, 0, 0, ACT_PASS, 12'h000, 3'h0);
    run_case(7'h01, KIND_REGULAR, 0, 0, ACT_STRIP, 12'h000, 3'h0);
    run_case(7'h03, KIND_UNTAGGED, 0, 0, ACT_CPU_TAG, 12'h000, 3'h0);
    run_case(7'h00, KIND_SPECIAL, 0, 0, ACT_STRIP, 12'h000, 3'h0);
    $display("test tag editing done");
    // Clock enable low freezes the port 0 result and drops the write address ready
    @(posedge clock);
    ce <= 1'b0;
    desc_in[0].valid <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("frozen", 32'h0, {31'h0, result_out[0].valid});
    check("ready", 32'h0, {31'h0, awready});
    @(posedge clock);
    ce <= 1'b1;
    @(posedge clock);
    #1;
    check("resumed", 32'h1, {31'h0, result_out[0].valid});
    $display("test clock enable done");
    complete_run();
  end
endmodule // egress_tag_rewrite_bench
